// [hdl/adcoi_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module adcoi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_ptr; // Write slot
  logic [AW-1:0] rd_ptr; // Read slot
  logic [AW:0] count; // Words held
  logic push; // Accepted write
  logic pop; // Accepted read
  logic [AW:0] next_count; // Fill after this cycle

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  assign out_valid = (count != '0);

  // Fill level; simultaneous push and pop keep it
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Pointers and level; ready is registered so the source sees a clean flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= (next_count < (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Data array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // A full FIFO must refuse further words
  chk_full_refuses: assert property (@(posedge clk) disable iff (sys_rst)
    (count == (AW+1)'(DEPTH)) |-> !in_ready)
    else $error("fifo full but ready");

endmodule : adcoi_fifo

// [hdl/adcoi_pkg.sv]
// Constants and types of the converter output interface configuration block
package adcoi_pkg;

  // Serial control frame layout, first bit in is the MSB
  localparam int FRAME_BITS = 32;
  localparam int HDR_W = 12;
  localparam logic [HDR_W-1:0] FRAME_HEADER = 12'h000;
  localparam logic [3:0] CFG_ADDR = 4'h1;
  localparam logic [4:0] FRAME_LAST = 5'h1F;

  // Configuration word field positions
  localparam int BIT_FIXED_ONE = 15;
  localparam int BIT_FIXED_ZERO = 14;
  localparam int BIT_DUAL_CLK_N = 13;
  localparam int BIT_DCS_EN = 12;
  localparam int BIT_PHASE_QUAD = 11;
  localparam int BIT_DOUBLE_RATE_N = 10;
  localparam int BIT_EDGE_DEMUX = 8;
  localparam logic [7:0] LOW_BYTE_ONES = 8'hFF;

  // Power-on value of the configuration word
  localparam logic [15:0] CFG_POR = 16'hB2FF;

  // Sample path sizes
  localparam int SAMPLE_W = 8;
  localparam int FIFO_DEPTH = 8;

  // One converted sample with its over-range mark
  typedef struct packed {
    logic over_range;
    logic [SAMPLE_W-1:0] sample;
  } adcoi_word_t;

  // Effective output settings after the mode selection
  typedef struct packed {
    logic dual_clock_out_n;
    logic duty_cycle_stabilizer_en;
    logic double_rate_n;
    logic edge_or_demux_select;
  } adcoi_cfg_t;

endpackage : adcoi_pkg

// [hdl/adcoi_top.sv]
// Output interface configuration register and data output formatter
`timescale 1ns/1ps
module adcoi_top
  import adcoi_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic scs_n,
  input wire logic sdata,
  input wire logic ext_ctrl_mode,
  input wire logic output_edge_pin,
  input wire logic [SAMPLE_W-1:0] sample_data,
  input wire logic sample_over_range,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic output_data_clock,
  output logic clock_or_over_range,
  output logic [2*SAMPLE_W-1:0] data_out,
  output logic duty_cycle_stabilizer_en
);

  ///////////////////////////////////////////////////////////////////////////
  // Serial control side, runs on the writer's clock
  logic [FRAME_BITS-2:0] frame_shift; // Bits received so far
  logic [4:0] frame_count; // Bit index within frame
  logic [15:0] wr_word; // Last accepted configuration word
  logic wr_toggle; // Flips once per accepted write
  logic [FRAME_BITS-1:0] frame_full; // Frame including current bit

  assign frame_full = {frame_shift, sdata};

  // Bit counter; chip select high ends a frame even with sclk stopped
  always_ff @(posedge sclk or posedge sys_rst or posedge scs_n) begin
    if (sys_rst || scs_n) begin
      frame_count <= '0;
    end else begin
      frame_count <= frame_count + 1'b1;
    end
  end

  // Shift register, MSB first
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_shift <= '0;
    end else if (!scs_n) begin
      frame_shift <= frame_full[FRAME_BITS-2:0];
    end
  end

  // Capture a complete, well-formed frame aimed at this register
  // Malformed words are dropped so a bad write cannot corrupt the clocks
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_word <= CFG_POR;
      wr_toggle <= 1'b0;
    end else if (!scs_n && frame_count == FRAME_LAST) begin
      if (frame_full[FRAME_BITS-1 -: HDR_W] == FRAME_HEADER &&
          frame_full[19:16] == CFG_ADDR &&
          frame_full[BIT_FIXED_ONE] && !frame_full[BIT_FIXED_ZERO] &&
          frame_full[7:0] == LOW_BYTE_ONES) begin
        wr_word <= frame_full[15:0];
        wr_toggle <= ~wr_toggle;
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Crossing into the sample clock domain
  logic [1:0] tgl_sync; // Toggle synchroniser, bit 0 is the first stage
  logic tgl_seen; // Last toggle value acted on
  logic [1:0] ext_sync; // Mode pin synchroniser
  logic [1:0] edge_sync; // Edge pin synchroniser
  logic [15:0] cfg_reg; // Configuration word in sample domain

  // Two-flop synchronisers for the toggle and both pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_sync <= '0;
      ext_sync <= '0;
      edge_sync <= '0;
      tgl_seen <= 1'b0;
    end else begin
      tgl_sync <= {tgl_sync[0], wr_toggle};
      ext_sync <= {ext_sync[0], ext_ctrl_mode};
      edge_sync <= {edge_sync[0], output_edge_pin};
      tgl_seen <= tgl_sync[1];
    end
  end

  // Word is stable long before the toggle lands, so sampling it is safe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= CFG_POR;
    end else if (tgl_sync[1] != tgl_seen) begin
      cfg_reg <= wr_word;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Effective settings: register in extended mode, defaults and the edge pin otherwise
  adcoi_cfg_t eff; // Settings in force
  always_comb begin
    if (ext_sync[1]) begin
      eff.dual_clock_out_n = cfg_reg[BIT_DUAL_CLK_N];
      eff.duty_cycle_stabilizer_en = cfg_reg[BIT_DCS_EN];
      eff.double_rate_n = cfg_reg[BIT_DOUBLE_RATE_N];
      eff.edge_or_demux_select = cfg_reg[BIT_EDGE_DEMUX];
    end else begin
      eff.dual_clock_out_n = CFG_POR[BIT_DUAL_CLK_N];
      eff.duty_cycle_stabilizer_en = CFG_POR[BIT_DCS_EN];
      eff.double_rate_n = CFG_POR[BIT_DOUBLE_RATE_N];
      eff.edge_or_demux_select = edge_sync[1];
    end
  end

  logic mode_sdr; // Single data rate
  logic mode_nd; // Double rate, not demultiplexed
  logic mode_dmx; // Double rate, demultiplexed
  assign mode_sdr = eff.double_rate_n;
  assign mode_nd = !eff.double_rate_n && eff.edge_or_demux_select;
  assign mode_dmx = !eff.double_rate_n && !eff.edge_or_demux_select;

  ///////////////////////////////////////////////////////////////////////////
  // Sample buffer
  adcoi_word_t fifo_in; // Word from the converter core
  adcoi_word_t fifo_out; // Word to the formatter
  logic fifo_valid; // Buffer holds a word
  logic fifo_ready; // Formatter takes a word
  logic [SAMPLE_W:0] fifo_raw; // Flat read data

  assign fifo_in = '{over_range: sample_over_range, sample: sample_data};
  assign fifo_out = fifo_raw;

  adcoi_fifo #(
    .WIDTH(SAMPLE_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(fifo_in),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_raw),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  ///////////////////////////////////////////////////////////////////////////
  // Output formatter
  logic half; // Demux: second word of a pair is due
  logic [SAMPLE_W-1:0] lo_word; // Demux: first word of a pair
  logic lo_or; // Demux: first word over-range
  logic or_flag; // Over-range of the word on the bus
  logic sdr_launch; // Single rate: this cycle makes the chosen edge
  logic sdr_last; // Single rate: a word was launched at the last edge
  logic take; // A word leaves the buffer
  logic next_output_data_clock; // Clock level after this edge
  logic next_or; // Over-range after this edge
  logic [2*SAMPLE_W-1:0] next_data; // Bus value after this edge

  // A change of edge select flips the launch phase; skipping one edge keeps one word per period
  assign sdr_launch = mode_sdr && !sdr_last && ((~output_data_clock) == eff.edge_or_demux_select);
  assign fifo_ready = mode_nd || mode_dmx || sdr_launch;
  assign take = fifo_ready && fifo_valid;

  // Next clock level, bus word and flag; underrun repeats the last word, or puts lo_word in both halves in demux
  always_comb begin
    next_output_data_clock = ~output_data_clock;
    next_or = or_flag;
    next_data = data_out;
    if (mode_dmx) begin
      next_output_data_clock = half ? ~output_data_clock : output_data_clock;
      if (half) begin
        next_data = {(take ? fifo_out.sample : lo_word), lo_word};
        next_or = lo_or | (take & fifo_out.over_range);
      end
    end else if (take) begin
      next_data = {{SAMPLE_W{1'b0}}, fifo_out.sample};
      next_or = fifo_out.over_range;
    end
  end

  // Remembers a single rate launch so two edges in a row never both carry a word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdr_last <= 1'b0;
    end else begin
      sdr_last <= sdr_launch;
    end
  end

  // Pair assembly for demultiplexed output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half <= 1'b0;
      lo_word <= '0;
      lo_or <= 1'b0;
    end else begin
      half <= mode_dmx ? ~half : 1'b0;
      if (mode_dmx && !half && take) begin
        lo_word <= fifo_out.sample;
        lo_or <= fifo_out.over_range;
      end
    end
  end

  // Registered bus pins; second pin is a clock copy or the over-range flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_data_clock <= 1'b0;
      clock_or_over_range <= 1'b0;
      data_out <= '0;
      or_flag <= 1'b0;
    end else begin
      output_data_clock <= next_output_data_clock;
      data_out <= next_data;
      or_flag <= next_or;
      clock_or_over_range <= eff.dual_clock_out_n ? next_or : next_output_data_clock;
    end
  end

  // Stabiliser control to the clock input stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty_cycle_stabilizer_en <= CFG_POR[BIT_DCS_EN];
    end else begin
      duty_cycle_stabilizer_en <= eff.duty_cycle_stabilizer_en;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_nd_hold;
    mode_nd [*2];
  endsequence

  sequence s_sdr_hold;
    mode_sdr [*3];
  endsequence

  chk_single_clk_or: assert property ($past(eff.dual_clock_out_n) |-> clock_or_over_range == or_flag)
    else $error("over-range pin does not carry the flag");
  chk_dual_clk_copy: assert property (!eff.dual_clock_out_n |=> clock_or_over_range == output_data_clock)
    else $error("second clock differs from first");
  chk_ddr_each_edge: assert property (s_nd_hold |-> output_data_clock != $past(output_data_clock))
    else $error("double rate clock missed an edge");
  chk_sdr_one_word: assert property (s_sdr_hold ##0 $changed(data_out) |-> $past(data_out) == $past(data_out, 2))
    else $error("single rate bus changed twice in a period");
  chk_sdr_edge_sel: assert property ($past(mode_sdr) && $changed(data_out) |->
    output_data_clock == $past(eff.edge_or_demux_select))
    else $error("single rate data moved on the wrong edge");
  chk_dmx_pair_clk: assert property ($past(mode_dmx) && $changed(output_data_clock) |-> $past(half))
    else $error("demux clock toggled mid pair");
  chk_normal_default: assert property (!ext_sync[1] |-> !mode_sdr ##1 (duty_cycle_stabilizer_en
    && clock_or_over_range == or_flag))
    else $error("register fields active in normal mode");
  chk_dcs_follow: assert property (##1 duty_cycle_stabilizer_en == $past(eff.duty_cycle_stabilizer_en))
    else $error("stabiliser enable does not follow setting");

endmodule : adcoi_top

// [tb/adcoi_host_model.sv]
// Host model that writes serial control frames into the converter
`timescale 1ns/1ps
module adcoi_host_model (
  output logic sclk,
  output logic scs_n,
  output logic sdata
);
  // Idle: select high, serial clock stopped
  initial begin
    sclk = 1'b0;
    scs_n = 1'b1;
    sdata = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // One 32-bit frame, MSB first, 80 ns serial clock only inside the frame
  task automatic send(input logic [31:0] f);
    #7 scs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdata = f[i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 scs_n = 1'b1;
    // Released line shows the inverse, so a stale bit never reads as valid
    sdata = ~sdata;
  endtask : send
endmodule : adcoi_host_model

// [tb/adcoi_top_tb.sv]
// Self-checking bench of the output interface configuration block
`timescale 1ns/1ps
module adcoi_top_tb;
  import adcoi_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_ctrl_mode = 1'b1;
  logic output_edge_pin = 1'b0;
  logic [SAMPLE_W-1:0] sample_data = 8'h00;
  logic sample_over_range;
  logic sample_valid = 1'b0;
  logic feed = 1'b0; // Sample source on or off
  logic acc = 1'b0; // Word taken at the last edge
  logic sclk, scs_n, sdata, sample_ready, output_data_clock, clock_or_over_range, duty_cycle_stabilizer_en;
  logic [2*SAMPLE_W-1:0] data_out;
  int failures = 0;
  int tests_run = 0;
  int tg, dc, bad, lv, orb, cpm, pr, nr; // Watch results
  // Odd words carry the over-range mark so the flag really moves
  assign sample_over_range = sample_data[0];
  adcoi_top adcoi_top_i (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .scs_n(scs_n), .sdata(sdata),
    .ext_ctrl_mode(ext_ctrl_mode), .output_edge_pin(output_edge_pin), .sample_data(sample_data),
    .sample_over_range(sample_over_range), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .output_data_clock(output_data_clock), .clock_or_over_range(clock_or_over_range),
    .data_out(data_out), .duty_cycle_stabilizer_en(duty_cycle_stabilizer_en));
  adcoi_host_model adcoi_host_model_i (.sclk(sclk), .scs_n(scs_n), .sdata(sdata));
  ////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Handshake seen at the rising edge, next word offered at the falling one
  always @(posedge clk) acc <= sample_valid & sample_ready;
  // An offered word stays offered until it is taken
  always @(negedge clk) begin
    if (!sample_valid || acc) sample_valid <= feed;
    if (acc) sample_data <= sample_data + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Configuration frame; bit 14 and low byte given by the caller
  function automatic logic [31:0] frm(logic d, logic s, logic r, logic o, logic b14, logic [7:0] lo);
    return {FRAME_HEADER, CFG_ADDR, 1'b1, b14, d, s, 1'b0, r, 1'b1, o, lo};
  endfunction : frm
  // Write, then leave room for the crossing into the sample clock
  task automatic wr(input logic [31:0] f);
    adcoi_host_model_i.send(f);
    repeat (12) @(negedge clk);
  endtask : wr
  // Counts clock toggles and data changes over n settled cycles
  task automatic watch(input int n, input logic lvl);
    logic pc;
    logic [15:0] pd;
    {tg, dc, bad, lv, orb, cpm, pr, nr} = '0;
    @(negedge clk);
    pc = output_data_clock;
    pd = data_out;
    repeat (n) begin
      @(negedge clk);
      if (output_data_clock !== pc) tg++;
      if (data_out !== pd) begin
        dc++;
        if (output_data_clock === pc) bad++;
        if (output_data_clock !== lvl) lv++;
        if (data_out[15:8] !== 8'(data_out[7:0] + 8'h01)) pr++;
      end
      if (clock_or_over_range !== data_out[0]) orb++;
      if (clock_or_over_range !== output_data_clock) cpm++;
      if (sample_ready !== 1'b1) nr++;
      pc = output_data_clock;
      pd = data_out;
    end
  endtask : watch
  ////////////////////////////////////////////////////////////////
  task automatic t_ddr();
    wr(frm(1, 1, 0, 1, 0, LOW_BYTE_ONES));
    watch(40, 1'b0);
    chk("ddr_toggles", tg, 40);
    chk("ddr_words", dc, 40);
    chk("ddr_aligned", bad, 0);
    chk("over_range", orb, 0);
  endtask : t_ddr
  task automatic t_regs();
    wr(frm(1, 0, 0, 1, 1, LOW_BYTE_ONES));
    chk("bit14_refused", duty_cycle_stabilizer_en, 1);
    wr(frm(1, 0, 0, 1, 0, 8'hFE));
    chk("lowbyte_refused", duty_cycle_stabilizer_en, 1);
    wr(frm(1, 0, 0, 1, 0, LOW_BYTE_ONES));
    chk("dcs_off", duty_cycle_stabilizer_en, 0);
    wr(frm(1, 1, 0, 1, 0, LOW_BYTE_ONES));
    chk("dcs_on", duty_cycle_stabilizer_en, 1);
  endtask : t_regs
  task automatic t_normal();
    ext_ctrl_mode = 1'b0;
    wr(frm(1, 0, 1, 1, 0, LOW_BYTE_ONES));
    chk("normal_dcs", duty_cycle_stabilizer_en, 1);
    watch(40, 1'b0);
    chk("normal_demux", tg, 20);
    output_edge_pin = 1'b1;
    repeat (12) @(negedge clk);
    watch(40, 1'b0);
    chk("normal_ddr", tg, 40);
    chk("normal_words", dc, 40);
    ext_ctrl_mode = 1'b1;
    repeat (12) @(negedge clk);
    chk("ext_stored_dcs", duty_cycle_stabilizer_en, 0);
  endtask : t_normal
  task automatic t_dual();
    wr(frm(0, 1, 0, 1, 0, LOW_BYTE_ONES));
    watch(40, 1'b0);
    chk("second_clock", cpm, 0);
    chk("dual_toggles", tg, 40);
  endtask : t_dual
  task automatic t_sdr();
    for (int o = 0; o < 2; o++) begin
      wr(frm(1, 1, 1, o[0], 0, LOW_BYTE_ONES));
      watch(40, o[0]);
      chk("sdr_toggles", tg, 40);
      chk("sdr_words", dc, 20);
      chk("sdr_edge", lv, 0);
      chk("buffer_full", 16'(nr > 0), 1);
    end
    // Source stops: buffer drains, last word repeats, clock keeps going
    feed = 1'b0;
    repeat (40) @(negedge clk);
    watch(40, 1'b1);
    chk("underrun_hold", dc, 0);
    chk("underrun_clock", tg, 40);
    chk("drained_ready", sample_ready, 1);
    feed = 1'b1;
  endtask : t_sdr
  task automatic t_demux();
    wr(frm(1, 1, 0, 0, 0, LOW_BYTE_ONES));
    watch(40, 1'b0);
    chk("demux_toggles", tg, 20);
    chk("demux_words", dc, 20);
    chk("demux_pairs", pr, 0);
  endtask : t_demux
  ////////////////////////////////////////////////////////////////
  // Main sequence: reset for 20 cycles, then the scenarios
  initial begin
    repeat (20) @(negedge clk);
    chk("dcs_reset", duty_cycle_stabilizer_en, 1);
    chk("ready_reset", sample_ready, 0);
    sys_rst = 1'b0;
    feed = 1'b1;
    repeat (12) @(negedge clk);
    t_ddr();
    t_regs();
    t_normal();
    t_dual();
    t_sdr();
    t_demux();
    finish_test();
  end
  // Watchdog: about ten frames of 2.6 us each fit well inside this
  initial begin
    #300000;
    failures++;
    finish_test();
  end
endmodule : adcoi_top_tb
